// ### logic/ext_state_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - task switched flag set: float or vector instruction faults device unavailable first
// - crc accumulate and bit count never raise device unavailable fault
// - move to control register zero writes the task switched flag
// - hardware task switch sets the task switched flag
// - clear switched flag instruction clears the task switched flag
// - save area: 512 byte legacy layout, 64 byte header, then component regions
// - feature query reports save support and operating system enable flags
// - enable bit in control register four plus per-component enable mask
// - mask readable at any privilege, writable only at most privileged level
// - restore and save act only on components selected by operand mask
// - save sets header bit of each component it wrote
// - header bits match enable mask bits one to one
// - header vector at offset 0; reserved bytes must be zero
// - selected enabled component with header bit one is loaded
// - selected enabled component with header bit zero gets init values
// - task switched flag sits at bit 3 of control register zero
// - writing zero to mask bit 0 faults instead of updating
module ext_state_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire ext_state_pkg::axil_req_t axiReq,
  output ext_state_pkg::axil_rsp_t axiRsp,
  input wire ext_state_pkg::op_req_t opReq,
  output ext_state_pkg::op_rsp_t opRsp
);

  ext_state_pkg::state_t st_q;
  ext_state_pkg::state_t st_d;
  logic [63:0] loadMask;
  logic [63:0] initMask;
  logic [63:0] storeMask;
  logic [63:0] headerOut;
  logic tsFlag;
  logic osxEnable;
  logic [31:0] queryWord;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // a mask value is legal only with component 0 on and no unknown component
  function automatic logic maskLegal(input logic [63:0] m);
    return m[0] && ((m & ~ext_state_pkg::MASK_SUPPORTED) == 64'h0);
  endfunction

  assign tsFlag = st_q.ctrl0[ext_state_pkg::TS_BIT];
  assign osxEnable = st_q.ctrl4[ext_state_pkg::OSX_BIT];

  // feature query word: support is fixed, enable mirrors control register four
  always_comb begin
    queryWord = 32'h0000_0000;
    queryWord[ext_state_pkg::QUERY_SUPPORT_BIT] = 1'b1;
    queryWord[ext_state_pkg::QUERY_OSX_BIT] = osxEnable;
  end

  ext_state_select u_select (
    .sel(opReq.operand),
    .enable(st_q.featMask),
    .headerIn(opReq.headerVec),
    .loadMask(loadMask),
    .initMask(initMask),
    .storeMask(storeMask),
    .headerOut(headerOut)
  );

  // ---------------------------------------------------------------
  // next state: bus slave first, then the instruction port
  // ---------------------------------------------------------------
  always_comb begin
    logic [63:0] newMask;
    logic touches;
    logic saveRest;
    logic ud;
    logic gp;
    logic nm;
    newMask = st_q.featMask;
    touches = 1'b0;
    saveRest = 1'b0;
    ud = 1'b0;
    gp = 1'b0;
    nm = 1'b0;
    st_d = st_q;
    st_d.rsp = '0;

    // address and data may come in either order; each is held until both are in
    if (axiReq.awvalid && !st_q.awHeld && !st_q.bvalid) begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !st_q.wHeld && !st_q.bvalid) begin
      st_d.wHeld = 1'b1;
      st_d.wData = axiReq.wdata;
      st_d.wStrb = axiReq.wstrb;
    end

    // write commits one cycle after both halves are held
    if (st_q.awHeld && st_q.wHeld && !st_q.bvalid) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = ext_state_pkg::RESP_OKAY;
      case (st_q.awAddr)
        ext_state_pkg::ADDR_CTRL0: begin
          st_d.ctrl0 = mergeBytes(st_q.ctrl0, st_q.wData, st_q.wStrb);
        end
        ext_state_pkg::ADDR_CTRL4: begin
          st_d.ctrl4 = mergeBytes(st_q.ctrl4, st_q.wData, st_q.wStrb);
        end
        ext_state_pkg::ADDR_MASK_LO, ext_state_pkg::ADDR_MASK_HI: begin
          if (st_q.awAddr == ext_state_pkg::ADDR_MASK_LO) begin
            newMask[31:0] = mergeBytes(st_q.featMask[31:0], st_q.wData, st_q.wStrb);
          end else begin
            newMask[63:32] = mergeBytes(st_q.featMask[63:32], st_q.wData, st_q.wStrb);
          end
          // an illegal mask is refused whole, the bus sees an error
          if (maskLegal(newMask)) begin
            st_d.featMask = newMask;
          end else begin
            st_d.bresp = ext_state_pkg::RESP_SLVERR;
          end
        end
        default: begin
          st_d.bresp = ext_state_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_q.bvalid && axiReq.bready) begin
      st_d.bvalid = 1'b0;
    end

    // read: one request at a time, answered the next cycle
    if (axiReq.arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = ext_state_pkg::RESP_OKAY;
      case (axiReq.araddr)
        ext_state_pkg::ADDR_CTRL0: st_d.rdata = st_q.ctrl0;
        ext_state_pkg::ADDR_CTRL4: st_d.rdata = st_q.ctrl4;
        ext_state_pkg::ADDR_MASK_LO: st_d.rdata = st_q.featMask[31:0];
        ext_state_pkg::ADDR_MASK_HI: st_d.rdata = st_q.featMask[63:32];
        ext_state_pkg::ADDR_QUERY: st_d.rdata = queryWord;
        ext_state_pkg::ADDR_HDR_LO: st_d.rdata = st_q.lastHdr[31:0];
        ext_state_pkg::ADDR_HDR_HI: st_d.rdata = st_q.lastHdr[63:32];
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = ext_state_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_q.rvalid && axiReq.rready) begin
      st_d.rvalid = 1'b0;
    end

    // instruction port: decided in one cycle, answered the next.
    // it runs after the bus so an instruction wins a same-cycle clash.
    if (opReq.valid) begin
      touches = (opReq.code == ext_state_pkg::OP_FLOAT) ||
                (opReq.code == ext_state_pkg::OP_VECTOR);
      saveRest = (opReq.code == ext_state_pkg::OP_SAVE) ||
                 (opReq.code == ext_state_pkg::OP_RESTORE);
      // new instructions only exist once the operating system enabled them
      ud = !osxEnable && (saveRest ||
           (opReq.code == ext_state_pkg::OP_READ_MASK) ||
           (opReq.code == ext_state_pkg::OP_WRITE_MASK));
      case (opReq.code)
        ext_state_pkg::OP_MOV_CR0, ext_state_pkg::OP_CLEAR_TS: begin
          gp = (opReq.priv != 2'h0);
        end
        ext_state_pkg::OP_WRITE_MASK: begin
          gp = (opReq.priv != 2'h0) || !maskLegal(opReq.operand);
        end
        ext_state_pkg::OP_SAVE: begin
          gp = ((opReq.areaBase[5:0] & ext_state_pkg::AREA_ALIGN_MASK) != 6'h0);
        end
        ext_state_pkg::OP_RESTORE: begin
          // misaligned area or nonzero reserved header bytes are refused
          gp = ((opReq.areaBase[5:0] & ext_state_pkg::AREA_ALIGN_MASK) != 6'h0) ||
               (opReq.headerRsvd != 64'h0);
        end
        default: begin
          gp = 1'b0;
        end
      endcase
      // general-purpose-only instructions never look at the flag
      nm = tsFlag && (touches || (saveRest &&
           ((opReq.operand[1:0] & st_q.featMask[1:0] &
             ext_state_pkg::LEGACY_COMPONENTS) != 2'h0)));

      st_d.rsp.done = 1'b1;
      st_d.rsp.udFault = ud;
      st_d.rsp.gpFault = !ud && gp;
      st_d.rsp.nmFault = !ud && !gp && nm;
      st_d.rsp.headerAddr = opReq.areaBase + ext_state_pkg::LEGACY_AREA_BYTES;

      if (!ud && !gp && !nm) begin
        case (opReq.code)
          ext_state_pkg::OP_MOV_CR0: begin
            st_d.ctrl0 = opReq.operand[31:0];
          end
          ext_state_pkg::OP_CLEAR_TS: begin
            st_d.ctrl0[ext_state_pkg::TS_BIT] = 1'b0;
          end
          ext_state_pkg::OP_TASK_SWITCH: begin
            st_d.ctrl0[ext_state_pkg::TS_BIT] = 1'b1;
          end
          ext_state_pkg::OP_READ_MASK: begin
            st_d.rsp.result = st_q.featMask;
          end
          ext_state_pkg::OP_WRITE_MASK: begin
            st_d.featMask = opReq.operand;
          end
          ext_state_pkg::OP_SAVE: begin
            st_d.rsp.storeMask = storeMask;
            st_d.rsp.headerVec = headerOut;
            st_d.lastHdr = headerOut;
          end
          ext_state_pkg::OP_RESTORE: begin
            st_d.rsp.loadMask = loadMask;
            st_d.rsp.initMask = initMask;
            st_d.rsp.headerVec = opReq.headerVec;
            st_d.lastHdr = opReq.headerVec;
          end
          default: begin
            st_d.rsp.result = 64'h0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.ctrl0 <= ext_state_pkg::CTRL0_RST;
      st_q.ctrl4 <= ext_state_pkg::CTRL4_RST;
      st_q.featMask <= ext_state_pkg::MASK_RST;
      st_q.lastHdr <= ext_state_pkg::HDR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs: ready terms are combinational, data comes from flops
  // ---------------------------------------------------------------
  assign axiRsp.awready = !st_q.awHeld && !st_q.bvalid;
  assign axiRsp.wready = !st_q.wHeld && !st_q.bvalid;
  assign axiRsp.bvalid = st_q.bvalid;
  assign axiRsp.bresp = st_q.bresp;
  assign axiRsp.arready = !st_q.rvalid;
  assign axiRsp.rvalid = st_q.rvalid;
  assign axiRsp.rdata = st_q.rdata;
  assign axiRsp.rresp = st_q.rresp;
  assign opRsp = st_q.rsp;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_nm_on_flag: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_FLOAT) && tsFlag
    |=> opRsp.done && opRsp.nmFault && !opRsp.gpFault)
    else $error("float op with flag set did not fault");

  a_gp_only_free: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_GP_ONLY) |=> !opRsp.nmFault)
    else $error("general purpose op raised device fault");

  a_mov_sets_flag: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_MOV_CR0) && (opReq.priv == 2'h0)
    |=> tsFlag == $past(opReq.operand[3]))
    else $error("move to control register zero lost flag");

  a_switch_sets: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_TASK_SWITCH) |=> tsFlag)
    else $error("task switch did not set flag");

  a_clear_flag: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_CLEAR_TS) && (opReq.priv == 2'h0)
    |=> !tsFlag)
    else $error("clear op left flag set");

  // an unprivileged move must fault and leave the flag where it was
  a_mov_unpriv: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_MOV_CR0) && (opReq.priv != 2'h0)
    |=> opRsp.gpFault && $stable(tsFlag))
    else $error("unprivileged move to control register zero accepted");

  a_vec_on_flag: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_VECTOR) && tsFlag
    |=> opRsp.done && opRsp.nmFault)
    else $error("vector op with flag set did not fault");

  a_query_mirror: assert property (
    axiReq.arvalid && axiRsp.arready && (axiReq.araddr == ext_state_pkg::ADDR_QUERY)
    |=> axiRsp.rvalid && axiRsp.rdata[27] == $past(osxEnable) && axiRsp.rdata[26])
    else $error("feature query flags wrong");

  a_mask_ring0: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_WRITE_MASK) && osxEnable &&
    (opReq.priv != 2'h0) |=> opRsp.gpFault && $stable(st_q.featMask))
    else $error("unprivileged mask write not refused");

  a_mask_bit0: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_WRITE_MASK) && osxEnable &&
    !opReq.operand[0] |=> opRsp.gpFault && st_q.featMask[0])
    else $error("mask bit 0 cleared without fault");

  a_restore_sel: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_RESTORE)
    |=> ((opRsp.loadMask | opRsp.initMask) & ~$past(opReq.operand)) == 64'h0 &&
        (opRsp.initMask & $past(opReq.headerVec)) == 64'h0)
    else $error("restore acted on unselected component");

  a_save_header: assert property (
    opReq.valid && (opReq.code == ext_state_pkg::OP_SAVE) && !tsFlag && osxEnable &&
    (opReq.areaBase[5:0] == 6'h0)
    |=> (opRsp.headerVec & opRsp.storeMask) == opRsp.storeMask && opRsp.storeMask ==
        ($past(opReq.operand) & $past(st_q.featMask)))
    else $error("save did not mark stored components");

  // a faulting instruction must not hand any component action to memory
  a_fault_no_mask: assert property (
    opRsp.done && (opRsp.nmFault || opRsp.gpFault || opRsp.udFault)
    |-> (opRsp.loadMask | opRsp.initMask | opRsp.storeMask) == 64'h0)
    else $error("faulting instruction reported component action");

endmodule
`default_nettype wire

// ### logic/ext_state_pkg.sv
`default_nettype none
package ext_state_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses on the register bus
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL4 = 8'h04;
  localparam logic [7:0] ADDR_MASK_LO = 8'h08;
  localparam logic [7:0] ADDR_MASK_HI = 8'h0C;
  localparam logic [7:0] ADDR_QUERY = 8'h10;
  localparam logic [7:0] ADDR_HDR_LO = 8'h14;
  localparam logic [7:0] ADDR_HDR_HI = 8'h18;

  // ---------------------------------------------------------------
  // field positions and values after reset
  // ---------------------------------------------------------------
  localparam int TS_BIT = 3;
  localparam int OSX_BIT = 18;
  localparam int QUERY_SUPPORT_BIT = 26;
  localparam int QUERY_OSX_BIT = 27;
  localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL4_RST = 32'h0000_0000;
  localparam logic [63:0] MASK_RST = 64'h0000_0000_0000_0001;
  localparam logic [63:0] MASK_SUPPORTED = 64'h0000_0000_0000_0003;
  localparam logic [63:0] HDR_RST = 64'h0000_0000_0000_0000;
  localparam logic [1:0] LEGACY_COMPONENTS = 2'h3;

  // ---------------------------------------------------------------
  // save area layout
  // ---------------------------------------------------------------
  localparam logic [31:0] LEGACY_AREA_BYTES = 32'h0000_0200;
  localparam logic [31:0] HEADER_BYTES = 32'h0000_0040;
  localparam logic [5:0] AREA_ALIGN_MASK = 6'h3F;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_FLOAT       = 4'h1,
    OP_VECTOR      = 4'h2,
    OP_GP_ONLY     = 4'h3,
    OP_MOV_CR0     = 4'h4,
    OP_CLEAR_TS    = 4'h5,
    OP_TASK_SWITCH = 4'h6,
    OP_READ_MASK   = 4'h7,
    OP_WRITE_MASK  = 4'h8,
    OP_SAVE        = 4'h9,
    OP_RESTORE     = 4'hA
  } op_code_t;

  typedef struct packed {
    logic valid;
    op_code_t code;
    logic [1:0] priv;
    logic [63:0] operand;
    logic [31:0] areaBase;
    logic [63:0] headerVec;
    logic [63:0] headerRsvd;
  } op_req_t;

  typedef struct packed {
    logic done;
    logic nmFault;
    logic gpFault;
    logic udFault;
    logic [63:0] result;
    logic [63:0] loadMask;
    logic [63:0] initMask;
    logic [63:0] storeMask;
    logic [63:0] headerVec;
    logic [31:0] headerAddr;
  } op_rsp_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic [31:0] ctrl0;
    logic [31:0] ctrl4;
    logic [63:0] featMask;
    logic [63:0] lastHdr;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    op_rsp_t rsp;
  } state_t;

endpackage
`default_nettype wire

// ### logic/ext_state_select.sv
`timescale 1ns/1ps
`default_nettype none
// per-component action of a save or a restore
module ext_state_select (
  input wire logic [63:0] sel,
  input wire logic [63:0] enable,
  input wire logic [63:0] headerIn,
  output logic [63:0] loadMask,
  output logic [63:0] initMask,
  output logic [63:0] storeMask,
  output logic [63:0] headerOut
);

  logic [63:0] active;

  // ---------------------------------------------------------------
  // bit i of every vector is component i, same order as the enable mask
  // ---------------------------------------------------------------
  assign active = sel & enable;
  assign loadMask = active & headerIn;
  // a clear header bit means init values, memory contents ignored
  assign initMask = active & ~headerIn;
  assign storeMask = active;
  // saved components are marked present, others keep their header bit
  assign headerOut = headerIn | active;

endmodule
`default_nettype wire

// ### testbench/os_save_area.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// save areas as the operating system lays them out
// ---------------------------------------------------------------
module os_save_area (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] areaBase,
  input wire ext_state_pkg::op_rsp_t opRsp,
  output logic [63:0] hdrVec,
  output logic [63:0] hdrRsvd
);
  logic [63:0] hdrMem [0:3];
  // one area per task, 1 KiB apart, picked by base bits 11:10; the lower base bits are not looked at
  assign hdrVec = hdrMem[areaBase[11:10]];
  // software never writes the reserved header bytes, so they read as zero
  assign hdrRsvd = 64'h0;
  // the header sits right after the 512-byte legacy image; a save writes it back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        hdrMem[i] <= 64'h0;
      end
    end else if (opRsp.done && opRsp.storeMask != 64'h0) begin
      hdrMem[opRsp.headerAddr[11:10]] <= opRsp.headerVec;
    end
  end
endmodule
`default_nettype wire

// ### testbench/lazy_ext_state_mgmt_test.sv
`timescale 1ns/1ps
`default_nettype none
module lazy_ext_state_mgmt_test;
  // ---------------------------------------------------------------
  // signals, design and save-area model
  // ---------------------------------------------------------------
  logic core_clk;
  logic rst;
  ext_state_pkg::axil_req_t axiReq;
  ext_state_pkg::axil_rsp_t axiRsp;
  ext_state_pkg::op_req_t opReq;
  ext_state_pkg::op_rsp_t opRsp;
  logic [31:0] memBase;
  logic [63:0] memHdr;
  logic [63:0] memRsvd;
  int errTotal;
  int cmpCount;
  int seed;
  logic [31:0] mCtrl0;
  logic mOsx;
  logic [63:0] mMask;

  ext_state_ctrl uut (.core_clk(core_clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .opReq(opReq), .opRsp(opRsp));
  os_save_area osMem (.core_clk(core_clk), .rst(rst), .areaBase(memBase), .opRsp(opRsp),
    .hdrVec(memHdr), .hdrRsvd(memRsvd));

  // core clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (errTotal == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // bus master
  // ---------------------------------------------------------------
  // ready is looked at mid-cycle, so each release follows the edge that took the item
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic bad);
    logic ga;
    logic gw;
    logic gb;
    logic [1:0] r;
    @(posedge core_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    gb = 1'b0;
    while (!gb) begin
      @(negedge core_clk);
      ga = axiReq.awvalid && axiRsp.awready;
      gw = axiReq.wvalid && axiRsp.wready;
      gb = axiRsp.bvalid;
      r = axiRsp.bresp;
      @(posedge core_clk);
      if (ga) axiReq.awvalid <= 1'b0;
      if (gw) axiReq.wvalid <= 1'b0;
    end
    axiReq.bready <= 1'b0;
    chk(64'(r), bad ? 64'(ext_state_pkg::RESP_SLVERR) : 64'(ext_state_pkg::RESP_OKAY));
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic bad);
    logic ga;
    logic gr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    gr = 1'b0;
    while (!gr) begin
      @(negedge core_clk);
      ga = axiReq.arvalid && axiRsp.arready;
      gr = axiRsp.rvalid;
      d = axiRsp.rdata;
      r = axiRsp.rresp;
      @(posedge core_clk);
      if (ga) axiReq.arvalid <= 1'b0;
    end
    axiReq.rready <= 1'b0;
    chk(64'(d), 64'(ed));
    chk(64'(r), bad ? 64'(ext_state_pkg::RESP_SLVERR) : 64'(ext_state_pkg::RESP_OKAY));
  endtask

  // ---------------------------------------------------------------
  // instruction port with reference model
  // ---------------------------------------------------------------
  // the model decides faults first, since a faulting instruction changes nothing
  task automatic op(input ext_state_pkg::op_code_t c, input logic [1:0] pv,
    input logic [63:0] o, input logic [31:0] b, input logic [63:0] hv, input logic [63:0] rs);
    ext_state_pkg::op_rsp_t e;
    logic ud;
    logic gp;
    logic nm;
    logic [63:0] se;
    e = '0;
    ud = 1'b0;
    gp = 1'b0;
    nm = 1'b0;
    se = o & mMask;
    case (c)
      ext_state_pkg::OP_FLOAT, ext_state_pkg::OP_VECTOR: nm = mCtrl0[ext_state_pkg::TS_BIT];
      ext_state_pkg::OP_MOV_CR0, ext_state_pkg::OP_CLEAR_TS: gp = pv != 2'h0;
      ext_state_pkg::OP_READ_MASK: ud = !mOsx;
      ext_state_pkg::OP_WRITE_MASK: begin
        ud = !mOsx;
        gp = pv != 2'h0 || !o[0] || (o & ~ext_state_pkg::MASK_SUPPORTED) != 64'h0;
      end
      ext_state_pkg::OP_SAVE, ext_state_pkg::OP_RESTORE: begin
        ud = !mOsx;
        gp = b[5:0] != 6'h0 || (c == ext_state_pkg::OP_RESTORE && rs != 64'h0);
        nm = mCtrl0[ext_state_pkg::TS_BIT] && se[1:0] != 2'h0;
      end
      default: ;
    endcase
    e.done = 1'b1;
    e.udFault = ud;
    e.gpFault = gp && !ud;
    e.nmFault = nm && !gp && !ud;
    if (!(ud || gp || nm)) begin
      case (c)
        ext_state_pkg::OP_MOV_CR0: mCtrl0 = o[31:0];
        ext_state_pkg::OP_CLEAR_TS: mCtrl0[ext_state_pkg::TS_BIT] = 1'b0;
        ext_state_pkg::OP_TASK_SWITCH: mCtrl0[ext_state_pkg::TS_BIT] = 1'b1;
        ext_state_pkg::OP_READ_MASK: e.result = mMask;
        ext_state_pkg::OP_WRITE_MASK: mMask = o;
        ext_state_pkg::OP_SAVE: begin
          e.storeMask = se;
          e.headerVec = hv | se;
        end
        ext_state_pkg::OP_RESTORE: begin
          e.loadMask = se & hv;
          e.initMask = se & ~hv;
        end
        default: ;
      endcase
    end
    @(posedge core_clk);
    opReq <= {1'b1, c, pv, o, b, hv, rs};
    @(posedge core_clk);
    opReq.valid <= 1'b0;
    @(negedge core_clk);
    chk(64'({opRsp.done, opRsp.nmFault, opRsp.gpFault, opRsp.udFault}),
      64'({e.done, e.nmFault, e.gpFault, e.udFault}));
    chk(opRsp.loadMask, e.loadMask);
    chk(opRsp.initMask, e.initMask);
    chk(opRsp.storeMask, e.storeMask);
    if (c == ext_state_pkg::OP_READ_MASK && !ud) chk(opRsp.result, e.result);
    if (e.storeMask != 64'h0) begin
      chk(opRsp.headerVec, e.headerVec);
      chk(64'(opRsp.headerAddr), 64'(b + ext_state_pkg::LEGACY_AREA_BYTES));
    end
  endtask

  task automatic op0(input ext_state_pkg::op_code_t c, input logic [1:0] pv, input logic [63:0] o);
    op(c, pv, o, 32'h0, 64'h0, 64'h0);
  endtask

  // hang guard, far beyond the thousand or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int unsigned rc;
    logic [1:0] pv;
    logic [63:0] o;
    seed = 95871;
    errTotal = 0;
    cmpCount = 0;
    rst = 1'b1;
    axiReq = '0;
    opReq = '0;
    memBase = 32'h0;
    mCtrl0 = ext_state_pkg::CTRL0_RST;
    mOsx = 1'b0;
    mMask = ext_state_pkg::MASK_RST;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    axr(ext_state_pkg::ADDR_CTRL0, 32'h0, 1'b0);
    axr(ext_state_pkg::ADDR_MASK_LO, 32'h1, 1'b0);
    axr(ext_state_pkg::ADDR_QUERY, 32'h0400_0000, 1'b0);
    axr(ext_state_pkg::ADDR_HDR_LO, 32'h0, 1'b0);
    axr(8'h1C, 32'h0, 1'b1);
    axw(ext_state_pkg::ADDR_QUERY, 32'hFFFF_FFFF, 1'b1);
    op(ext_state_pkg::OP_SAVE, 2'h0, 64'h3, 32'h400, 64'h0, 64'h0);
    op0(ext_state_pkg::OP_READ_MASK, 2'h3, 64'h0);
    mOsx = 1'b1;
    axw(ext_state_pkg::ADDR_CTRL4, 32'h0004_0000, 1'b0);
    axr(ext_state_pkg::ADDR_QUERY, 32'h0C00_0000, 1'b0);
    op0(ext_state_pkg::OP_READ_MASK, 2'h3, 64'h0);
    op0(ext_state_pkg::OP_WRITE_MASK, 2'h3, 64'h3);
    op0(ext_state_pkg::OP_WRITE_MASK, 2'h0, 64'h2);
    op0(ext_state_pkg::OP_WRITE_MASK, 2'h0, 64'h3);
    axw(ext_state_pkg::ADDR_MASK_LO, 32'h2, 1'b1);
    axr(ext_state_pkg::ADDR_MASK_LO, 32'h3, 1'b0);
    op0(ext_state_pkg::OP_MOV_CR0, 2'h1, 64'h8);
    op0(ext_state_pkg::OP_MOV_CR0, 2'h0, 64'h8);
    axr(ext_state_pkg::ADDR_CTRL0, 32'h8, 1'b0);
    op0(ext_state_pkg::OP_CLEAR_TS, 2'h0, 64'h0);
    // lazy switch: the new task faults once, the handler clears the flag and swaps state
    op0(ext_state_pkg::OP_TASK_SWITCH, 2'h0, 64'h0);
    op0(ext_state_pkg::OP_VECTOR, 2'h3, 64'h0);
    op0(ext_state_pkg::OP_GP_ONLY, 2'h3, 64'h0);
    op(ext_state_pkg::OP_SAVE, 2'h0, 64'h3, 32'h400, memHdr, memRsvd);
    op0(ext_state_pkg::OP_CLEAR_TS, 2'h3, 64'h0);
    op0(ext_state_pkg::OP_CLEAR_TS, 2'h0, 64'h0);
    op(ext_state_pkg::OP_SAVE, 2'h0, 64'h3, 32'h400, memHdr, memRsvd);
    axr(ext_state_pkg::ADDR_HDR_LO, 32'h3, 1'b0);
    memBase = 32'h800;
    #1;
    op(ext_state_pkg::OP_RESTORE, 2'h0, 64'h3, 32'h800, memHdr, memRsvd);
    op0(ext_state_pkg::OP_FLOAT, 2'h3, 64'h0);
    @(posedge core_clk);
    memBase = 32'h400;
    #1;
    chk(memHdr, 64'h3);
    op(ext_state_pkg::OP_RESTORE, 2'h0, 64'h2, 32'h400, memHdr, memRsvd);
    op(ext_state_pkg::OP_RESTORE, 2'h0, 64'h3, 32'h400, memHdr, 64'h1);
    op(ext_state_pkg::OP_SAVE, 2'h0, 64'h3, 32'h420, memHdr, memRsvd);
    // random instruction mix; the enable bit is flipped now and then over the bus
    for (int i = 0; i < 400; i++) begin
      if (i % 80 == 40) begin
        mOsx = !mOsx;
        axw(ext_state_pkg::ADDR_CTRL4, {13'h0, mOsx, 18'h0}, 1'b0);
        axr(ext_state_pkg::ADDR_QUERY, {4'h0, mOsx, 1'b1, 26'h0}, 1'b0);
      end
      rc = {$random(seed)} % 11;
      pv = ($random(seed) & 1) ? 2'h0 : 2'($random(seed));
      o = ($random(seed) & 1) ? 64'({$random(seed)} & 3) : {$random(seed), $random(seed)};
      op(ext_state_pkg::op_code_t'(rc[3:0]), pv, o, 32'($random(seed)) & 32'h0000_0C01,
        64'({$random(seed)} & 3), ($random(seed) % 8 == 0) ? 64'h1 : 64'h0);
    end
    axr(ext_state_pkg::ADDR_CTRL0, mCtrl0, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
